// ==== design/fpcbu_pkg.sv ====
// Types shared by the FP condition branch unit.
// Assumes fpcbu_regs.svh is on the include path.
package fpcbu_pkg;
    `include "fpcbu_regs.svh"

    // Branch unit sequencing
    typedef enum logic [1:0] {
        FPCBU_IDLE = 2'h0,
        FPCBU_SLOT = 2'h1
    } fpcbu_state_t;

    // Branch request from decode
    typedef struct packed {
        logic valid;
        logic [31:0] instr;
        logic [63:0] pc;
    } fpcbu_req_t;

    // Redirect and nullify result toward fetch
    typedef struct packed {
        logic redirect;
        logic nullify;
        logic [63:0] target;
    } fpcbu_resp_t;

    // Complete module state
    typedef struct packed {
        fpcbu_state_t st;
        logic cond;
        logic null_sel;
        logic [63:0] target;
        logic redirect;
        logic nullify;
        logic cpu_exc;
        logic ri_exc;
        logic unimp_exc;
        logic [7:0] cond_bits;
        logic [2:0] ctrl;
        logic [`FPCBU_EV_W-1:0] irq;
        logic [`FPCBU_EV_W-1:0] mask;
        logic [31:0] taken_cnt;
        logic [31:0] prdata;
    } fpcbu_st_t;
endpackage

// ==== design/fpcbu_regs.svh ====
// Offsets, field positions and reset values for the FP condition branch unit.
// Assumes it is included by its bare name from the package only.
`ifndef FPCBU_REGS_SVH
`define FPCBU_REGS_SVH

// Register byte offsets on APB (32-bit data, one word each)
`define FPCBU_CTRL_OFS 12'h000
`define FPCBU_STAT_OFS 12'h004
`define FPCBU_IRQ_OFS 12'h008
`define FPCBU_MASK_OFS 12'h00c
`define FPCBU_CNT_OFS 12'h010
`define FPCBU_ADDR_W 12

// Control register fields
`define FPCBU_CTRL_CU_BIT 0
`define FPCBU_CTRL_LEGACY_BIT 1
`define FPCBU_CTRL_UNIMP_BIT 2
`define FPCBU_CTRL_RST 3'h1

// Interrupt status bit positions
`define FPCBU_EV_TAKEN 0
`define FPCBU_EV_NULL 1
`define FPCBU_EV_CPU 2
`define FPCBU_EV_RI 3
`define FPCBU_EV_UNIMP 4
`define FPCBU_EV_W 5

// Branch instruction fields
`define FPCBU_OP_HI 31
`define FPCBU_OP_LO 26
`define FPCBU_RS_HI 25
`define FPCBU_RS_LO 21
`define FPCBU_SEL_HI 20
`define FPCBU_SEL_LO 18
`define FPCBU_NULL_BIT 17
`define FPCBU_POL_BIT 16
`define FPCBU_OFF_HI 15
`define FPCBU_OFF_LO 0
`define FPCBU_OP_COP1 6'h11
`define FPCBU_RS_BC 5'h08

// Offset geometry: 16-bit field scaled by four bytes
`define FPCBU_OFF_W 16
`define FPCBU_SHIFT 2
`define FPCBU_NCC 8

`endif

// ==== design/fpcbu_top.sv ====
// FP condition-code branch unit: evaluates false/true/likely branches,
// forms targets, redirects after the delay slot and nullifies it.
// Assumes decode presents one branch at a time, a slot_done pulse when
// the delay-slot instruction retires, and compare writes on pclk.
`timescale 1ns/1ns
module fpcbu_top
    import fpcbu_pkg::*;
#(
    parameter int REG_W = 64
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [`FPCBU_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire fpcbu_req_t br_req,
    input wire logic slot_done,
    input wire logic cmp_we,
    input wire logic [2:0] cmp_sel,
    input wire logic cmp_val,
    output fpcbu_resp_t br_resp,
    output logic coproc_condition_signal,
    output logic [7:0] fp_status_cond,
    output logic exc_cop_unusable,
    output logic exc_reserved,
    output logic exc_fp_unimpl,
    output logic busy
);

    // Target arithmetic is sized for the package types
    initial begin
        if (REG_W != 64) begin
            $error("fpcbu_top supports only REG_W of 64");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State and decode signals
    fpcbu_st_t s_q; // All registered state
    fpcbu_st_t s_d; // Next state
    logic is_bc; // Decoded FP condition branch
    logic [2:0] condition_select; // Which condition bit to test
    logic true_false_select; // Branch on 1 when set
    logic nullify_slot_select; // Likely variant
    logic [7:0] cond_now; // Condition bits incl. same-cycle compare
    logic sel_bit; // Tested condition bit
    logic [REG_W-1:0] target_offset; // Sign-extended scaled offset
    logic [`FPCBU_EV_W-1:0] ev; // Events this cycle
    logic acc; // APB access phase
    logic hit; // Mapped address

    ////////////////////////////////////////////////////////////////////////
    // Instruction field decode
    always_comb begin
        is_bc = br_req.instr[`FPCBU_OP_HI:`FPCBU_OP_LO] == `FPCBU_OP_COP1 &&
                br_req.instr[`FPCBU_RS_HI:`FPCBU_RS_LO] == `FPCBU_RS_BC;
        condition_select = br_req.instr[`FPCBU_SEL_HI:`FPCBU_SEL_LO];
        true_false_select = br_req.instr[`FPCBU_POL_BIT];
        nullify_slot_select = br_req.instr[`FPCBU_NULL_BIT];
        // Legacy mode forces selector zero, matching the short form
        if (s_q.ctrl[`FPCBU_CTRL_LEGACY_BIT]) begin
            condition_select = 3'h0;
        end
        // Forward a compare landing this cycle so the branch sees it
        cond_now = s_q.cond_bits;
        if (cmp_we) begin
            cond_now[cmp_sel] = cmp_val;
        end
        sel_bit = cond_now[condition_select];
        // Shift left two, sign-extend the 18-bit result
        target_offset = {{(REG_W-`FPCBU_OFF_W-`FPCBU_SHIFT)
                          {br_req.instr[`FPCBU_OFF_HI]}},
                         br_req.instr[`FPCBU_OFF_HI:`FPCBU_OFF_LO],
                         {`FPCBU_SHIFT{1'b0}}};
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic: branch sequencing and register file
    always_comb begin
        s_d = s_q;
        ev = '0;
        acc = psel && penable;
        hit = 1'b1;
        s_d.redirect = 1'b0;
        s_d.nullify = 1'b0;
        s_d.cpu_exc = 1'b0;
        s_d.ri_exc = 1'b0;
        s_d.unimp_exc = 1'b0;
        // Compare results are stored in the condition file
        if (cmp_we) begin
            s_d.cond_bits[cmp_sel] = cmp_val;
        end
        unique case (s_q.st)
            FPCBU_IDLE: begin
                if (br_req.valid && is_bc) begin
                    // Exceptions take priority over evaluation
                    if (!s_q.ctrl[`FPCBU_CTRL_CU_BIT]) begin
                        s_d.cpu_exc = 1'b1;
                        ev[`FPCBU_EV_CPU] = 1'b1;
                    end else if (s_q.ctrl[`FPCBU_CTRL_LEGACY_BIT] &&
                                 br_req.instr[`FPCBU_SEL_HI:`FPCBU_SEL_LO] != 3'h0) begin
                        s_d.ri_exc = 1'b1;
                        ev[`FPCBU_EV_RI] = 1'b1;
                    end else if (s_q.ctrl[`FPCBU_CTRL_UNIMP_BIT]) begin
                        s_d.unimp_exc = 1'b1;
                        ev[`FPCBU_EV_UNIMP] = 1'b1;
                    end else begin
                        // Evaluate now, act after the slot instruction
                        s_d.cond = (sel_bit == true_false_select);
                        s_d.null_sel = nullify_slot_select;
                        // Delay-slot address is the branch address plus one word
                        s_d.target = br_req.pc + 64'h4 + target_offset;
                        s_d.st = FPCBU_SLOT;
                        // Likely and not taken: kill the slot before it runs
                        if (nullify_slot_select && sel_bit != true_false_select) begin
                            s_d.nullify = 1'b1;
                            ev[`FPCBU_EV_NULL] = 1'b1;
                        end
                    end
                end
            end
            FPCBU_SLOT: begin
                // Control moves only once the slot instruction is done
                if (slot_done) begin
                    s_d.st = FPCBU_IDLE;
                    if (s_q.cond) begin
                        s_d.redirect = 1'b1;
                        s_d.taken_cnt = s_q.taken_cnt + 32'h1;
                        ev[`FPCBU_EV_TAKEN] = 1'b1;
                    end
                end
            end
        endcase
        // APB register access; reads of the IRQ register clear interrupt status after
        s_d.prdata = 32'h0;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `FPCBU_CTRL_OFS: s_d.prdata = {29'h0, s_q.ctrl};
                `FPCBU_STAT_OFS: s_d.prdata = {22'h0, s_q.st == FPCBU_SLOT, s_q.cond,
                                               cond_now};
                `FPCBU_IRQ_OFS: s_d.prdata = {27'h0, s_q.irq};
                `FPCBU_MASK_OFS: s_d.prdata = {27'h0, s_q.mask};
                `FPCBU_CNT_OFS: s_d.prdata = s_q.taken_cnt;
                default: s_d.prdata = 32'h0;
            endcase
        end
        unique case (paddr)
            `FPCBU_CTRL_OFS, `FPCBU_STAT_OFS, `FPCBU_IRQ_OFS,
            `FPCBU_MASK_OFS, `FPCBU_CNT_OFS: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        if (acc && pwrite && hit) begin
            if (paddr == `FPCBU_CTRL_OFS) begin
                s_d.ctrl = pwdata[2:0];
            end
            if (paddr == `FPCBU_MASK_OFS) begin
                s_d.mask = pwdata[`FPCBU_EV_W-1:0];
            end
        end
        // Status read clears, but a new event in that cycle survives
        if (acc && !pwrite && paddr == `FPCBU_IRQ_OFS) begin
            s_d.irq = '0;
        end
        s_d.irq = s_d.irq | ev;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{st: FPCBU_IDLE, ctrl: `FPCBU_CTRL_RST, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign pready = 1'b1;
    assign pslverr = acc && !hit;
    assign prdata = s_q.prdata;
    assign irq = |(s_q.irq & s_q.mask);
    assign br_resp = '{redirect: s_q.redirect, nullify: s_q.nullify, target: s_q.target};
    assign coproc_condition_signal = s_q.cond_bits[0];
    assign fp_status_cond = s_q.ctrl[`FPCBU_CTRL_LEGACY_BIT] ?
                            {7'h0, s_q.cond_bits[0]} : s_q.cond_bits;
    assign exc_cop_unusable = s_q.cpu_exc;
    assign exc_reserved = s_q.ri_exc;
    assign exc_fp_unimpl = s_q.unimp_exc;
    assign busy = s_q.st == FPCBU_SLOT;

endmodule

// ==== testbench/fpcbu_partner.sv ====
// Model of the FP compare unit and the fetch pipeline beside the branch unit.
// Assumes the bench requests compares on cmp_go and sets the slot latency.
`timescale 1ns/1ns
module fpcbu_fp_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic busy,
    input wire logic cmp_go,
    input wire logic [2:0] go_sel,
    input wire logic go_val,
    input wire logic [3:0] slot_lat,
    output logic cmp_we,
    output logic [2:0] cmp_sel,
    output logic cmp_val,
    output logic slot_done
);
    logic [3:0] cnt; // Cycles the delay slot has been in flight
    logic sent; // Slot already reported for this branch

    // Idle compare lines toggle, so a stale value never looks valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_we <= 1'b0;
            cmp_sel <= 3'h0;
            cmp_val <= 1'b0;
            cnt <= 4'h0;
            sent <= 1'b0;
            slot_done <= 1'b0;
        end else begin
            cmp_we <= cmp_go;
            cmp_sel <= cmp_go ? go_sel : ~cmp_sel;
            cmp_val <= cmp_go ? go_val : ~cmp_val;
            slot_done <= busy && !sent && cnt == slot_lat;
            sent <= busy && (sent || cnt == slot_lat);
            cnt <= (busy && !sent) ? cnt + 4'h1 : 4'h0;
        end
    end
endmodule

// ==== testbench/fpcbu_props.sv ====
// Checker for the FP condition branch unit: redirect, nullify, exception
// and APB timing. Sees only top-level ports; bound in at the foot.
`timescale 1ns/1ns
module fpcbu_props
    import fpcbu_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic slot_done,
    input wire logic cmp_we,
    input wire logic [2:0] cmp_sel,
    input wire logic cmp_val,
    input wire fpcbu_resp_t br_resp,
    input wire logic coproc_condition_signal,
    input wire logic [7:0] fp_status_cond,
    input wire logic exc_cop_unusable,
    input wire logic busy
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_slot_first:
        assert property (br_resp.redirect |-> $past(slot_done) && !busy) else $error("early redirect");
    chk_null_waits:
        assert property (br_resp.nullify |-> !br_resp.redirect && busy) else $error("bad nullify");
    chk_redir_pulse:
        assert property (br_resp.redirect |=> !br_resp.redirect) else $error("redirect too long");
    chk_slot_retire:
        assert property (slot_done && busy |=> !busy) else $error("slot not retired");
    chk_cmp_lands:
        assert property (cmp_we && cmp_sel == 3'h0 |=> coproc_condition_signal == $past(cmp_val))
        else $error("compare lost");
    chk_cc_mirror:
        assert property (coproc_condition_signal == fp_status_cond[0]) else $error("mirror differs");
    chk_exc_pulse:
        assert property (exc_cop_unusable |=> !exc_cop_unusable) else $error("long exception");
    chk_zero_wait:
        assert property (psel && penable |-> pready) else $error("bus wait state");
endmodule

bind fpcbu_top fpcbu_props i_fpcbu_props (.pclk, .presetn, .psel, .penable, .pready,
    .slot_done, .cmp_we, .cmp_sel, .cmp_val, .br_resp, .coproc_condition_signal,
    .fp_status_cond, .exc_cop_unusable, .busy);

// ==== testbench/fpcbu_top_test.sv ====
// Self-checking bench for the FP condition branch unit.
// Assumes the checker is bound in and the partner model retires slots.
`timescale 1ns/1ns
module fpcbu_top_test;
    import fpcbu_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cmp_go = 0, go_val = 0;
    logic pready, pslverr, irq, slot_done, cmp_we, cmp_val, ccs, eu, er, ef, busy, err;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [2:0] cmp_sel, go_sel = '0;
    logic [3:0] slot_lat = '0;
    logic [7:0] fsc, ccm = '0; // ccm: expected condition bits
    fpcbu_req_t br_req = '0;
    fpcbu_resp_t br_resp;
    int fails = 0, tests_run = 0, taken = 0;

    always #5 pclk = ~pclk;

    fpcbu_top i_fpcbu_top (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .irq, .br_req, .slot_done, .cmp_we, .cmp_sel, .cmp_val,
        .br_resp, .coproc_condition_signal(ccs), .fp_status_cond(fsc), .exc_cop_unusable(eu),
        .exc_reserved(er), .exc_fp_unimpl(ef), .busy);
    fpcbu_fp_partner i_fpcbu_fp_partner (.pclk, .presetn, .busy, .cmp_go, .go_sel,
        .go_val, .slot_lat, .cmp_we, .cmp_sel, .cmp_val, .slot_done);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer with an idle cycle after it; pready is waited for
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge pclk);
            n++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask

    // One branch; x is the exception set expected as {unusable, reserved, unimpl}
    task automatic branch(input logic [2:0] s, input logic nul, input logic pol,
        input logic [15:0] off, input logic [63:0] pc, input logic [2:0] x);
        logic take;
        int n = 0;
        take = ccm[s] == pol && x == 3'h0;
        br_req <= '{1'b1, {6'h11, 5'h08, s, nul, pol, off}, pc};
        @(posedge pclk);
        br_req.valid <= 1'b0;
        #1;
        chk({eu, er, ef, br_resp.nullify}, {x, nul & !take & (x == 3'h0)});
        while (busy === 1'b1 && n < 40) begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk({br_resp.redirect, busy}, {take, 1'b0});
        if (take)
            chk(br_resp.target, pc + 64'h4 + {{46{off[15]}}, off, 2'b00});
        taken += take;
        @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Every variant on every selector over mixed bits, prompt and slow slots
    task automatic t_variants();
        logic [7:0] p = 8'h96;
        chk({irq, busy, ccs}, 3'h0);
        for (int i = 0; i < 8; i++) begin
            go_sel <= i[2:0];
            go_val <= p[i];
            cmp_go <= 1;
            @(posedge pclk);
            cmp_go <= 0;
            ccm[i] = p[i];
            @(posedge pclk);
        end
        // Last compare lands on the edge just passed; let it settle
        @(posedge pclk);
        chk(fsc, p);
        for (int i = 0; i < 8; i++) begin
            slot_lat <= {1'b0, i[2:0]};
            for (int k = 0; k < 4; k++)
                branch(i[2:0], k[1], k[0], i[0] ? 16'h8000 : 16'h7ffc, 64'h1000 * i, 3'h0);
        end
    endtask

    // A compare landing with the branch must be the value tested
    task automatic t_forward();
        go_sel <= 3'h5;
        go_val <= ~ccm[5];
        cmp_go <= 1;
        @(posedge pclk);
        cmp_go <= 0;
        ccm[5] = ~ccm[5];
        branch(3'h5, 1'b1, 1'b1, 16'h0010, 64'h2000, 3'h0);
    endtask

    // Status, mask, read-clear and the taken counter
    task automatic t_irq();
        apb(1, 12'h00c, 32'h1);
        chk(irq, 1);
        apb(0, 12'h008, 0);
        chk({irq, rd}, {1'b0, 32'h3});
        apb(1, 12'h00c, 32'h0);
        branch(3'h5, 1'b0, 1'b1, 16'h0, 64'h0, 3'h0);
        chk(irq, 0);
        apb(0, 12'h008, 0);
        chk(rd, 32'h1);
        apb(0, 12'h010, 0);
        chk(rd, taken);
        // Status: idle, last branch held, condition bits as written
        apb(0, 12'h004, 0);
        chk(rd, {22'h0, 2'b01, ccm});
    endtask

    // Exceptions on branches that would fall through anyway, and a bad address
    task automatic t_exc();
        apb(1, 12'h000, 32'h0);
        branch(3'h0, 1'b0, ~ccm[0], 16'h4, 64'h0, 3'h4);
        apb(1, 12'h000, 32'h3);
        branch(3'h1, 1'b0, ~ccm[1], 16'h4, 64'h0, 3'h2);
        chk(fsc, {7'h0, ccm[0]});
        apb(1, 12'h000, 32'h5);
        apb(0, 12'h000, 0);
        chk(rd, 32'h5);
        branch(3'h2, 1'b0, ~ccm[2], 16'h4, 64'h0, 3'h1);
        apb(0, 12'h014, 0);
        chk({err, rd}, {1'b1, 32'h0});
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_variants();
        t_forward();
        t_irq();
        t_exc();
        print_verdict();
    end

    // Watchdog: the whole run needs only a few hundred cycles
    initial begin
        #100000;
        fails++;
        print_verdict();
    end
endmodule
